/* File: rtl/nvac_defines.vh */
`ifndef NVAC_DEFINES_VH
`define NVAC_DEFINES_VH

// ----------------------------------------------------------------------
// Register select codes on the special function register port
// ----------------------------------------------------------------------
`define NVAC_SEL_CONTROL      3'h0
`define NVAC_SEL_KEY          3'h1
`define NVAC_SEL_DATA         3'h2
`define NVAC_SEL_ADDR_LOW     3'h3
`define NVAC_SEL_ADDR_HIGH    3'h4
`define NVAC_SEL_DONE_FLAG    3'h5

// ----------------------------------------------------------------------
// Control register fields and done flag register bit
// ----------------------------------------------------------------------
`define NVAC_BIT_MEM_SEL      7
`define NVAC_BIT_CFG_SEL      6
`define NVAC_BIT_ROW_ERASE    4
`define NVAC_BIT_ABORTED      3
`define NVAC_BIT_WR_ENABLE    2
`define NVAC_BIT_WR_START     1
`define NVAC_BIT_RD_START     0
`define NVAC_BIT_DONE_FLAG    4

// ----------------------------------------------------------------------
// Unlock key values
// ----------------------------------------------------------------------
`define NVAC_KEY_FIRST        8'h55
`define NVAC_KEY_SECOND       8'haa

// ----------------------------------------------------------------------
// Address, data and timing
// ----------------------------------------------------------------------
`define NVAC_ADDR_W           10
`define NVAC_ADDR_HI_W        2
`define NVAC_DEPTH            1024
`define NVAC_WRITE_TIME_NS    20'h00fa0
`define NVAC_CLK_PERIOD_NS    20'h00004
`define NVAC_WRITE_CYCLES     (`NVAC_WRITE_TIME_NS / `NVAC_CLK_PERIOD_NS)
`define NVAC_TIMER_W          20
`define NVAC_ZERO_BYTE        8'h00
`define NVAC_TIMER_ONE        20'h00001

`endif

/* File: rtl/nvac_mem.v */
`default_nettype none

module nvac_mem (
  // Clock
  input  wire        i_ref_clk,
  // Port
  input  wire        i_we,
  input  wire [9:0]  i_addr,
  input  wire [7:0]  i_wdata,
  output reg  [7:0]  o_rdata
);

  reg [7:0] mem [0:1023];

  always @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end

endmodule

`default_nettype wire

/* File: rtl/nvac_timer.v */
`include "nvac_defines.vh"
`default_nettype none

module nvac_timer #(
  parameter [19:0] CYCLES = `NVAC_WRITE_CYCLES
) (
  // Clock and reset
  input  wire i_ref_clk,
  input  wire i_srst,
  // Control
  input  wire i_start,
  output reg  o_busy,
  output wire o_done
);

  reg [19:0] cnt_q;

  assign o_done = o_busy && (cnt_q == `NVAC_TIMER_ONE);

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      cnt_q  <= 20'h00000;
      o_busy <= 1'b0;
    end else if (i_start) begin
      cnt_q  <= CYCLES;
      o_busy <= 1'b1;
    end else if (o_busy) begin
      cnt_q <= cnt_q - `NVAC_TIMER_ONE;
      if (o_done) begin
        o_busy <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

/* File: rtl/nvac_top.v */
`include "nvac_defines.vh"
`default_nettype none

module nvac_top #(
  parameter [19:0] WRITE_CYCLES = `NVAC_WRITE_CYCLES
) (
  // Clock and reset
  input  wire        i_ref_clk,
  input  wire        i_srst,
  // Reset cause: high when the reset in progress came from power-up
  input  wire        i_por,
  // Register port
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire [2:0]  i_sel,
  input  wire [7:0]  i_wdata,
  output reg  [7:0]  o_rdata,
  // Status
  output wire        o_nvm_done_flag,
  output wire        o_busy,
  output wire        o_flash_start,
  output wire        o_row_erase_start,
  output wire        o_cfg_start
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  localparam [2:0] KEY_IDLE  = 3'b001;
  localparam [2:0] KEY_FIRST = 3'b010;
  localparam [2:0] KEY_OPEN  = 3'b100;

  reg  [2:0] key_q;
  reg  [7:0] addr_lo_q;
  reg  [1:0] addr_hi_q;
  reg  [7:0] data_q;
  reg        memory_select_q;
  reg        configuration_select_q;
  reg        row_erase_q;
  reg        aborted_write_q;
  reg        store_unlock_enable_q;
  reg        wr_start_q;
  reg        rd_start_q;
  reg        rd_pend_q;
  reg        nvm_done_flag_q;
  reg        por_seen_q;
  wire [7:0] mem_rdata;
  wire       tmr_busy;
  wire       tmr_done;
  wire       start_ok;
  wire       ctl_wr;
  wire [9:0] addr;

  assign addr   = {addr_hi_q, addr_lo_q};
  assign ctl_wr = i_wr && (i_sel == `NVAC_SEL_CONTROL) && !wr_start_q;
  // Start is honoured only with the enable already stored and the key open.
  assign start_ok = ctl_wr && i_wdata[`NVAC_BIT_WR_START] && store_unlock_enable_q
                    && (key_q == KEY_OPEN);

  assign o_nvm_done_flag    = nvm_done_flag_q;
  assign o_busy             = wr_start_q;
  assign o_flash_start      = start_ok && memory_select_q && !configuration_select_q
                              && !row_erase_q;
  assign o_row_erase_start  = start_ok && !configuration_select_q && row_erase_q;
  assign o_cfg_start        = start_ok && configuration_select_q;

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  nvac_timer #(
    .CYCLES  (WRITE_CYCLES)
  ) u_timer (
    .i_ref_clk (i_ref_clk),
    .i_srst    (i_srst),
    .i_start   (start_ok),
    .o_busy    (tmr_busy),
    .o_done    (tmr_done)
  );

  // Erase-before-write is a single self-timed store of the new byte.
  nvac_mem u_mem (
    .i_ref_clk (i_ref_clk),
    .i_we      (tmr_done && !memory_select_q && !configuration_select_q),
    .i_addr    (addr),
    .i_wdata   (data_q),
    .o_rdata   (mem_rdata)
  );

  // ----------------------------------------------------------------------
  // Unlock key sequencer
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      key_q <= KEY_IDLE;
    end else if (i_wr) begin
      // Any register write other than the next key step closes the key.
      case (key_q)
        KEY_IDLE: begin
          key_q <= (i_sel == `NVAC_SEL_KEY && i_wdata == `NVAC_KEY_FIRST)
                   ? KEY_FIRST : KEY_IDLE;
        end
        KEY_FIRST: begin
          key_q <= (i_sel == `NVAC_SEL_KEY && i_wdata == `NVAC_KEY_SECOND)
                   ? KEY_OPEN : KEY_IDLE;
        end
        KEY_OPEN: begin
          key_q <= KEY_IDLE;
        end
        default: begin
          key_q <= KEY_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Address pair and data byte ignore port writes while a write runs.
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      addr_lo_q <= `NVAC_ZERO_BYTE;
      addr_hi_q <= 2'h0;
      data_q    <= `NVAC_ZERO_BYTE;
    end else begin
      if (rd_pend_q) begin
        data_q <= mem_rdata;
      end
      if (i_wr && !wr_start_q) begin
        case (i_sel)
          `NVAC_SEL_ADDR_LOW: begin
            addr_lo_q <= i_wdata;
          end
          `NVAC_SEL_ADDR_HIGH: begin
            addr_hi_q <= i_wdata[`NVAC_ADDR_HI_W-1:0];
          end
          `NVAC_SEL_DATA: begin
            data_q <= i_wdata;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Write enable, row erase and write start
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      row_erase_q           <= 1'b0;
      store_unlock_enable_q <= 1'b0;
      wr_start_q            <= 1'b0;
    end else begin
      if (ctl_wr) begin
        row_erase_q           <= i_wdata[`NVAC_BIT_ROW_ERASE];
        store_unlock_enable_q <= i_wdata[`NVAC_BIT_WR_ENABLE];
      end
      if (start_ok) begin
        wr_start_q <= 1'b1;
      end
      if (tmr_done) begin
        wr_start_q <= 1'b0;
        if (row_erase_q) begin
          row_erase_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read start
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      rd_start_q <= 1'b0;
      rd_pend_q  <= 1'b0;
    end else begin
      rd_start_q <= 1'b0;
      rd_pend_q  <= rd_start_q;
      if (ctl_wr && i_wdata[`NVAC_BIT_RD_START] && !memory_select_q
          && !configuration_select_q && !i_wdata[`NVAC_BIT_MEM_SEL]
          && !i_wdata[`NVAC_BIT_CFG_SEL]) begin
        rd_start_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Completion flag
  // ----------------------------------------------------------------------
  // Hardware set wins over a software clear in the same cycle.
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      nvm_done_flag_q <= 1'b0;
    end else if (tmr_done) begin
      nvm_done_flag_q <= 1'b1;
    end else if (i_wr && (i_sel == `NVAC_SEL_DONE_FLAG)
                 && !i_wdata[`NVAC_BIT_DONE_FLAG]) begin
      nvm_done_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Power-up marker
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      por_seen_q <= i_por;
    end else begin
      por_seen_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Select bits and error flag
  // ----------------------------------------------------------------------
  // Select bits and the error flag survive a warm reset.
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      if (tmr_busy) begin
        aborted_write_q <= 1'b1;
      end
    end else begin
      if (ctl_wr) begin
        memory_select_q        <= i_wdata[`NVAC_BIT_MEM_SEL];
        configuration_select_q <= i_wdata[`NVAC_BIT_CFG_SEL];
        aborted_write_q        <= i_wdata[`NVAC_BIT_ABORTED];
      end
      if (ctl_wr && i_wdata[`NVAC_BIT_WR_START] && !start_ok) begin
        aborted_write_q <= 1'b1;
      end else if (tmr_done) begin
        aborted_write_q <= 1'b0;
      end
      if (por_seen_q) begin
        memory_select_q        <= 1'b0;
        configuration_select_q <= 1'b0;
        aborted_write_q        <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_rdata <= `NVAC_ZERO_BYTE;
    end else if (i_rd) begin
      case (i_sel)
        `NVAC_SEL_CONTROL: begin
          o_rdata <= {memory_select_q, configuration_select_q, 1'b0,
                      row_erase_q, aborted_write_q, store_unlock_enable_q,
                      wr_start_q, rd_start_q};
        end
        `NVAC_SEL_KEY: begin
          o_rdata <= `NVAC_ZERO_BYTE;
        end
        `NVAC_SEL_DATA: begin
          o_rdata <= data_q;
        end
        `NVAC_SEL_ADDR_LOW: begin
          o_rdata <= addr_lo_q;
        end
        `NVAC_SEL_ADDR_HIGH: begin
          o_rdata <= {6'h00, addr_hi_q};
        end
        `NVAC_SEL_DONE_FLAG: begin
          o_rdata <= {3'h0, nvm_done_flag_q, 4'h0};
        end
        default: begin
          o_rdata <= `NVAC_ZERO_BYTE;
        end
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: testbench/nvac_props.sv */
`default_nettype none
module nvac_props #(
  parameter [19:0] WRITE_CYCLES = 20'h00008
) (
  // Clock and reset
  input wire logic       i_ref_clk,
  input wire logic       i_srst,
  // Register port
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [2:0] i_sel,
  input wire logic [7:0] i_wdata,
  // Status
  input wire logic [7:0] o_rdata,
  input wire logic       o_nvm_done_flag,
  input wire logic       o_busy,
  input wire logic       o_flash_start,
  input wire logic       o_row_erase_start,
  input wire logic       o_cfg_start
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [19:0] bcnt_q;
  wire logic   go = o_flash_start | o_row_erase_start | o_cfg_start;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);
  // ----------------------------------------------------------------
  // Busy length counter and properties.
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    bcnt_q <= (i_srst || !o_busy) ? 20'h00000 : bcnt_q + 20'h00001;
  end
  property p_busy_len; $fell(o_busy) |-> bcnt_q == WRITE_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("write time wrong");
  property p_done_fall; $fell(o_busy) |-> o_nvm_done_flag; endproperty
  a_done_fall: assert property (p_done_fall) else $error("done not set");
  property p_done_keep; o_nvm_done_flag && !(i_wr && i_sel == 3'h5) |=> o_nvm_done_flag;
  endproperty
  a_done_keep: assert property (p_done_keep) else $error("done lost");
  property p_done_set; $rose(o_nvm_done_flag) |-> $fell(o_busy); endproperty
  a_done_set: assert property (p_done_set) else $error("done without end");
  property p_start_idle; go |-> !o_busy; endproperty
  a_start_idle: assert property (p_start_idle) else $error("start while busy");
  property p_start_cause; go |-> i_wr && i_sel == 3'h0 && i_wdata[1]; endproperty
  a_start_cause: assert property (p_start_cause) else $error("start without write");
  property p_busy_cause;
    $rose(o_busy) |-> $past(i_wr) && $past(i_sel) == 3'h0 && $past(i_wdata[1]);
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
  property p_key_zero; i_rd && i_sel == 3'h1 |=> o_rdata == 8'h00; endproperty
  a_key_zero: assert property (p_key_zero) else $error("key port not zero");
  property p_addr_hi; i_rd && i_sel == 3'h4 |=> o_rdata[7:2] == 6'h00; endproperty
  a_addr_hi: assert property (p_addr_hi) else $error("high address bits");
  c_done: cover property ($fell(o_busy));
  c_erase: cover property (o_row_erase_start);
  c_cfg: cover property (o_cfg_start);
endmodule
`default_nettype wire

/* File: testbench/nvac_top_tb_top.sv */
`default_nettype none
module nvac_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [2:0] s; logic [7:0] d; logic [7:0] e;} nvac_row_t;
  localparam int W = 8;
  logic       i_ref_clk = 1'b0;
  logic       i_srst    = 1'b1;
  logic       i_por     = 1'b1;
  logic       i_wr      = 1'b0;
  logic       i_rd      = 1'b0;
  logic [2:0] i_sel     = 3'h0;
  logic [7:0] i_wdata   = 8'h00;
  logic [7:0] o_rdata;
  logic       o_nvm_done_flag;
  logic       o_busy;
  logic       o_flash_start;
  logic       o_row_erase_start;
  logic       o_cfg_start;
  logic [7:0] v;
  int         errors = 0;
  int         cmp_count = 0;
  int         n;
  int         n_fs = 0;
  int         n_rs = 0;
  int         n_cs = 0;
  logic [7:0] m[2] = '{8'h80, 8'h40};
  logic [7:0] md[3] = '{8'h84, 8'h94, 8'h44};
  nvac_row_t  rows[6] = '{'{3'h3, 8'ha5, 8'ha5}, '{3'h4, 8'hff, 8'h03},
    '{3'h2, 8'h3c, 8'h3c}, '{3'h1, 8'h55, 8'h00}, '{3'h0, 8'hd8, 8'hd8},
    '{3'h0, 8'h00, 8'h00}};
  nvac_top #(.WRITE_CYCLES(20'(W))) dut_u (
    .i_ref_clk         (i_ref_clk),
    .i_srst            (i_srst),
    .i_por             (i_por),
    .i_wr              (i_wr),
    .i_rd              (i_rd),
    .i_sel             (i_sel),
    .i_wdata           (i_wdata),
    .o_rdata           (o_rdata),
    .o_nvm_done_flag   (o_nvm_done_flag),
    .o_busy            (o_busy),
    .o_flash_start     (o_flash_start),
    .o_row_erase_start (o_row_erase_start),
    .o_cfg_start       (o_cfg_start)
  );
  initial begin
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  always @(posedge i_ref_clk) begin
    n_fs <= n_fs + (o_flash_start === 1'b1);
    n_rs <= n_rs + (o_row_erase_start === 1'b1);
    n_cs <= n_cs + (o_cfg_start === 1'b1);
  end
  // ----------------------------------------------------------------
  // Bus cycles and checks.
  // ----------------------------------------------------------------
  task automatic results();
    if (errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_wr = 1'b1;
    i_sel = s;
    i_wdata = d;
    @(negedge i_ref_clk);
    i_wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] s);
    @(negedge i_ref_clk);
    i_rd = 1'b1;
    i_sel = s;
    @(negedge i_ref_clk);
    i_rd = 1'b0;
    v = o_rdata;
  endtask
  task automatic rchk(input logic [2:0] s, input logic [7:0] e);
    rd(s);
    chk($sformatf("register %0d", s), e, v);
  endtask
  task automatic key();
    wr(3'h1, 8'h55);
    wr(3'h1, 8'haa);
  endtask
  task automatic idle(input int x);
    n = 0;
    while (o_busy === 1'b1 && n < 200) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n >= 200) begin
      errors++;
      results();
    end
    chk("busy cycles", x[7:0], n[7:0]);
  endtask
  task automatic rst(input logic p);
    i_srst = 1'b1;
    i_por = p;
    repeat (12) @(negedge i_ref_clk);
    i_srst = 1'b0;
    i_por = 1'b0;
    @(negedge i_ref_clk);
  endtask
  task automatic eew(input logic [9:0] a, input logic [7:0] d);
    wr(3'h4, {6'h3f, a[9:8]});
    wr(3'h3, a[7:0]);
    wr(3'h2, d);
    wr(3'h0, 8'h04);
    key();
    wr(3'h0, 8'h06);
    wr(3'h2, ~d);
    wr(3'h3, ~a[7:0]);
    idle(W - 4);
    chk("done flag pin", 8'h01, {7'h00, o_nvm_done_flag});
    rchk(3'h2, d);
    rchk(3'h0, 8'h04);
    rchk(3'h5, 8'h10);
    wr(3'h5, 8'h00);
    rchk(3'h5, 8'h00);
    chk("done flag pin", 8'h00, {7'h00, o_nvm_done_flag});
  endtask
  task automatic eer(input logic [9:0] a, input logic [7:0] d);
    wr(3'h4, {6'h00, a[9:8]});
    wr(3'h3, a[7:0]);
    wr(3'h0, 8'h01);
    repeat (2) @(negedge i_ref_clk);
    rchk(3'h2, d);
    rchk(3'h0, 8'h00);
  endtask
  task automatic nogo();
    wr(3'h0, 8'h06);
    chk("busy", 8'h00, {7'h00, o_busy});
    rd(3'h0);
    chk("error bit", 8'h08, v & 8'h08);
  endtask
  // ----------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------
  initial begin
    rst(1'b1);
    rchk(3'h0, 8'h00);
    rchk(3'h5, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i].s, rows[i].d);
      rchk(rows[i].s, rows[i].e);
    end
    eew(10'h3ff, 8'h5a);
    eew(10'h000, 8'hc3);
    eer(10'h3ff, 8'h5a);
    eer(10'h000, 8'hc3);
    wr(3'h2, 8'h77);
    foreach (m[i]) begin
      wr(3'h0, m[i]);
      wr(3'h0, m[i] | 8'h01);
      repeat (2) @(negedge i_ref_clk);
      rchk(3'h2, 8'h77);
    end
    wr(3'h0, 8'h04);
    nogo();
    wr(3'h0, 8'h04);
    wr(3'h1, 8'haa);
    wr(3'h1, 8'h55);
    nogo();
    wr(3'h0, 8'h04);
    wr(3'h1, 8'h55);
    wr(3'h2, 8'h00);
    wr(3'h1, 8'haa);
    nogo();
    wr(3'h0, 8'h00);
    key();
    nogo();
    chk("flash starts", 8'h00, n_fs[7:0]);
    foreach (md[i]) begin
      wr(3'h0, md[i]);
      key();
      wr(3'h0, md[i] | 8'h02);
      idle(W);
      rchk(3'h0, md[i] & 8'hef);
    end
    chk("flash start seen", 8'h01, {7'h00, n_fs > 0});
    chk("erase starts", 8'h01, n_rs[7:0]);
    chk("config starts", 8'h01, n_cs[7:0]);
    wr(3'h0, 8'h84);
    key();
    wr(3'h0, 8'h86);
    rst(1'b0);
    chk("busy", 8'h00, {7'h00, o_busy});
    rd(3'h0);
    chk("abort state", 8'h88, v & 8'hc8);
    rst(1'b1);
    rchk(3'h0, 8'h00);
    results();
  end
endmodule
bind nvac_top nvac_props #(.WRITE_CYCLES(WRITE_CYCLES)) u_props (
  .i_ref_clk         (i_ref_clk),
  .i_srst            (i_srst),
  .i_wr              (i_wr),
  .i_rd              (i_rd),
  .i_sel             (i_sel),
  .i_wdata           (i_wdata),
  .o_rdata           (o_rdata),
  .o_nvm_done_flag   (o_nvm_done_flag),
  .o_busy            (o_busy),
  .o_flash_start     (o_flash_start),
  .o_row_erase_start (o_row_erase_start),
  .o_cfg_start       (o_cfg_start)
);
`default_nettype wire
